//--- hdl/fpc_ctrl.sv
// Flash protection, power modes, reset and secure region controller
`timescale 1ns/100ps
module fpc_ctrl #(
  parameter int PROG_CYCLES = 64,
  parameter int ERASE_CYCLES = 1000,
  parameter logic [15:0] MAKER_ID = 16'h005A, // Arbitrary identification value
  parameter logic [15:0] DEVICE_ID = 16'h1234, // Arbitrary identification value
  parameter logic [15:0] UNIQUE_SERIAL_ID = 16'hC0DE // Arbitrary serial word pattern
) (
  input wire logic clk, // 50 MHz clock
  input wire logic nrst, // Hardware reset, active low
  input wire fpc_pkg::fpc_bus_t bus, // Host select, strobes, address, write data
  input wire logic wp_n, // Write-protect, active low
  input wire logic accel_lockout_input, // Low disables all program and erase
  input wire logic supply_lockout_threshold, // High while supply below lockout
  input wire logic burst_next, // Advance burst address in sync mode
  input wire logic sw_prot, // Software protection of queried sector
  input wire logic [15:0] arr_rdata, // Array read data for arr_raddr
  output logic [fpc_pkg::SECT_W-1:0] sw_prot_sector, // Sector queried for software protection
  output logic [fpc_pkg::ADDR_W-1:0] arr_raddr, // Array read address
  output fpc_pkg::fpc_op_t arr_op, // Program or erase pulse to array
  output logic [15:0] dq_out, // Read data
  output logic dq_oe, // Read data output enable
  output logic data_valid, // Read data latched and valid
  output logic standby, // Standby state
  output logic auto_sleep, // Automatic sleep state
  output logic busy, // Program or erase running
  output logic secure_mode, // Sector 0 mapped to secure region
  output logic sync_mode, // Configuration: synchronous burst reads
  output logic factory_lock_flag, // Factory region locked
  output logic customer_lock_flag // Customer region locked
);
  import fpc_pkg::*;

  // ****************************************
  // State and storage
  // ****************************************
  fpc_state_t s_q;
  fpc_state_t s_d;
  logic [DATA_W-1:0] cust_mem [CUST_WORDS];
  logic sec_wr;
  logic [6:0] sec_widx;
  logic [DATA_W-1:0] sec_wdata;
  logic we_rise;
  logic ce_fall;
  logic in_sect0;
  logic boot_sect;
  logic blocked;
  logic [ADDR_W-1:0] burst_inc;

  // Word fetched for an address in the present mode
  function automatic logic [DATA_W-1:0] rd_src(input logic [ADDR_W-1:0] a, input fpc_state_t s,
                                               input logic [DATA_W-1:0] cword, input logic [DATA_W-1:0] aword);
    logic [DATA_W-1:0] w;
    w = aword;
    if (s.id_mode) begin
      w = '0;
      if (a[7:0] == ID_MAKER_ADDR) begin
        w = MAKER_ID;
      end else if (a[7:0] == ID_DEV_ADDR) begin
        w = DEVICE_ID;
      end else if (a[7:0] == ID_LOCK_ADDR) begin
        w[FACT_LOCK_BIT] = 1'b1;
        w[CUST_LOCK_BIT] = s.cust_lock;
      end
    end else if (s.secure && a[ADDR_W-1:SECT_LSB] == '0) begin
      if (s.busy || a[SECT_LSB-1:8] != '0) begin
        w = INVALID_WORD;
      end else if (a[CUST_BIT]) begin
        w = s.cust_used[a[6:0]] ? cword : ERASED_WORD;
      end else begin
        w = UNIQUE_SERIAL_ID ^ {9'h000, a[6:0]};
      end
    end else if (s.secure && s.busy && a[ADDR_W-1:BANK_LSB] == '0) begin
      w = INVALID_WORD;
    end
    return w;
  endfunction

  // ****************************************
  // Decode helpers
  // ****************************************
  assign we_rise = !s_q.we_prev && bus.we_n && !bus.ce_n && s_q.started && !s_q.pu_inh;
  assign ce_fall = s_q.ce_prev && !bus.ce_n;
  assign in_sect0 = bus.addr[ADDR_W-1:SECT_LSB] == '0;
  assign sw_prot_sector = bus.addr[ADDR_W-1:SECT_LSB];
  assign boot_sect = sw_prot_sector < WP_SECTS || sw_prot_sector > (SECT_LAST - WP_SECTS);
  // Hardware pins override software settings only when they protect
  assign blocked = (!wp_n && boot_sect) || !accel_lockout_input || supply_lockout_threshold || sw_prot;
  assign burst_inc = (s_q.secure && s_q.rd_addr[ADDR_W-1:SECT_LSB] == '0) ?
                     {s_q.rd_addr[ADDR_W-1:8], s_q.rd_addr[7:0] + 8'h01} : s_q.rd_addr + 24'h000001;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    sec_wr = 1'b0;
    sec_widx = bus.addr[6:0];
    sec_wdata = bus.data;
    s_d.we_prev = bus.we_n;
    s_d.ce_prev = bus.ce_n;
    s_d.op.pgm = 1'b0;
    s_d.op.ers = 1'b0;
    // Power-up strobe inhibit, caught once after release
    if (!s_q.started) begin
      s_d.started = 1'b1;
      s_d.pu_inh = !bus.we_n && !bus.ce_n && bus.oe_n;
    end else if (s_q.pu_inh && bus.we_n) begin
      s_d.pu_inh = 1'b0;
    end
    // Embedded operation countdown; continues while deselected
    if (s_q.busy) begin
      if (s_q.eng_cnt <= 16'h0001) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.eng_cnt = s_q.eng_cnt - 16'h0001;
      end
    end
    // Command sequencer
    if (supply_lockout_threshold) begin
      s_d.cmd = FPC_IDLE;
      s_d.busy = 1'b0;
      s_d.secure = 1'b0;
      s_d.id_mode = 1'b0;
    end else if (we_rise) begin
      s_d.cmd = FPC_IDLE;
      if (bus.data == CMD_RESET && s_q.cmd != FPC_CFGW) begin
        s_d.id_mode = 1'b0;
      end else begin
        unique case (s_q.cmd)
          FPC_IDLE: begin
            if (bus.addr[11:0] == UNLOCK_A1 && bus.data == CMD_UNL1_D) begin
              s_d.cmd = FPC_UNL1;
            end
          end
          FPC_UNL1: begin
            if (bus.addr[11:0] == UNLOCK_A2 && bus.data == CMD_UNL2_D) begin
              s_d.cmd = FPC_UNL2;
            end
          end
          FPC_UNL2: begin
            if (bus.addr[11:0] == UNLOCK_A1) begin
              if (bus.data == CMD_SEC_ENTER) begin
                s_d.secure = 1'b1;
              end else if (bus.data == CMD_SEC_EXIT) begin
                if (s_q.secure) begin
                  s_d.secure = 1'b0;
                end else begin
                  s_d.id_mode = 1'b1;
                end
              end else if (bus.data == CMD_PROG && !s_q.busy) begin
                s_d.cmd = FPC_PROG;
              end else if (bus.data == CMD_ERASE && !s_q.busy) begin
                s_d.cmd = FPC_ERS;
              end else if (bus.data == CMD_CFG) begin
                s_d.cmd = FPC_CFGW;
              end else if (bus.data == CMD_CUST_LOCK && s_q.secure) begin
                s_d.cust_lock = 1'b1;
              end
            end
          end
          FPC_PROG: begin
            if (s_q.secure && in_sect0) begin
              // Customer half only, single pass, no accelerated path
              if (!s_q.cust_lock && bus.addr[CUST_BIT] && bus.addr[SECT_LSB-1:8] == '0 &&
                  accel_lockout_input) begin
                sec_wr = 1'b1;
                sec_wdata = s_q.cust_used[bus.addr[6:0]] ? (cust_mem[bus.addr[6:0]] & bus.data) : bus.data;
                s_d.cust_used[bus.addr[6:0]] = 1'b1;
                s_d.busy = 1'b1;
                s_d.eng_cnt = 16'(PROG_CYCLES);
              end
            end else if (!blocked) begin
              s_d.op.pgm = 1'b1;
              s_d.op.addr = bus.addr;
              s_d.op.data = bus.data;
              s_d.busy = 1'b1;
              s_d.eng_cnt = 16'(PROG_CYCLES);
            end
          end
          FPC_ERS: begin
            if (bus.data == CMD_ERASE_GO && !blocked && !(s_q.secure && in_sect0)) begin
              s_d.op.ers = 1'b1;
              s_d.op.addr = bus.addr;
              s_d.op.data = bus.data;
              s_d.busy = 1'b1;
              s_d.eng_cnt = 16'(ERASE_CYCLES);
            end
          end
          FPC_CFGW: begin
            s_d.cfg_sync = bus.data[0];
          end
        endcase
      end
    end
    // Read path
    if (bus.ce_n) begin
      s_d.drive = 1'b0;
      s_d.acc_cnt = '0;
      s_d.sleep = 1'b0;
    end else if (s_q.cfg_sync) begin
      s_d.sleep = 1'b0;
      if (ce_fall) begin
        s_d.rd_addr = bus.addr;
        s_d.acc_cnt = '0;
        s_d.drive = 1'b0;
      end else if (s_q.acc_cnt < ACC_CYC) begin
        s_d.acc_cnt = s_q.acc_cnt + 4'h1;
      end else begin
        s_d.dq = rd_src(s_q.rd_addr, s_q, cust_mem[s_q.rd_addr[6:0]], arr_rdata);
        s_d.drive = 1'b1;
        if (burst_next) begin
          s_d.rd_addr = burst_inc;
        end
      end
    end else begin
      if (ce_fall || bus.addr != s_q.rd_addr) begin
        s_d.rd_addr = bus.addr;
        s_d.acc_cnt = '0;
        s_d.sleep = 1'b0;
        s_d.drive = 1'b0;
      end else if (s_q.acc_cnt < SLEEP_CYC) begin
        s_d.acc_cnt = s_q.acc_cnt + 4'h1;
        if (s_q.acc_cnt == ACC_CYC - 4'h1) begin
          s_d.dq = rd_src(s_q.rd_addr, s_q, cust_mem[s_q.rd_addr[6:0]], arr_rdata);
          s_d.drive = 1'b1;
        end
        if (s_q.acc_cnt == SLEEP_CYC - 4'h1) begin
          s_d.sleep = 1'b1;
        end
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.we_prev <= 1'b1;
      s_q.ce_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Customer words, no reset here; reset clears cust_used, so they read as erased after it
  always_ff @(posedge clk) begin
    if (sec_wr) begin
      cust_mem[sec_widx] <= sec_wdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign arr_raddr = s_q.rd_addr;
  assign arr_op = s_q.op;
  assign dq_out = s_q.dq;
  assign dq_oe = s_q.drive && !bus.oe_n && !bus.ce_n;
  assign data_valid = s_q.drive;
  assign standby = bus.ce_n && !s_q.busy && s_q.started;
  assign auto_sleep = s_q.sleep;
  assign busy = s_q.busy;
  assign secure_mode = s_q.secure;
  assign sync_mode = s_q.cfg_sync;
  assign factory_lock_flag = 1'b1;
  assign customer_lock_flag = s_q.cust_lock;
endmodule

//--- hdl/fpc_pkg.sv
// Shared constants, types and bus carriers of the flash protection and secure region controller
package fpc_pkg;
  // ****************************************
  // Widths and address map
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int SECT_LSB = 14;
  localparam int SECT_W = ADDR_W - SECT_LSB;
  localparam int BANK_LSB = 20;
  localparam logic [SECT_W-1:0] WP_SECTS = 10'h002;
  localparam logic [SECT_W-1:0] SECT_LAST = 10'h3FF;
  localparam logic [11:0] UNLOCK_A1 = 12'h555;
  localparam logic [11:0] UNLOCK_A2 = 12'h2AA;
  localparam int SEC_WORDS = 256;
  localparam int CUST_WORDS = 128;
  localparam int CUST_BIT = 7;
  localparam int FACT_LOCK_BIT = 7;
  localparam int CUST_LOCK_BIT = 6;
  localparam logic [7:0] ID_MAKER_ADDR = 8'h00;
  localparam logic [7:0] ID_DEV_ADDR = 8'h01;
  localparam logic [7:0] ID_LOCK_ADDR = 8'h03;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
  localparam logic [DATA_W-1:0] INVALID_WORD = 16'hFFFF;

  // ****************************************
  // Command data codes
  // ****************************************
  localparam logic [15:0] CMD_UNL1_D = 16'h00AA;
  localparam logic [15:0] CMD_UNL2_D = 16'h0055;
  localparam logic [15:0] CMD_SEC_ENTER = 16'h0088;
  localparam logic [15:0] CMD_SEC_EXIT = 16'h0090;
  localparam logic [15:0] CMD_PROG = 16'h00A0;
  localparam logic [15:0] CMD_ERASE = 16'h0080;
  localparam logic [15:0] CMD_ERASE_GO = 16'h0030;
  localparam logic [15:0] CMD_CFG = 16'h00C0;
  localparam logic [15:0] CMD_CUST_LOCK = 16'h0060;
  localparam logic [15:0] CMD_RESET = 16'h00F0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 20;
  localparam int ADDR_ACCESS_NS = 80;
  localparam int SELECT_ACCESS_NS = 80;
  localparam int SLEEP_EXTRA_NS = 20;
  localparam int ACC_CYC_I = (ADDR_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SEL_CYC_I = (SELECT_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_CYC_I = (ADDR_ACCESS_NS + SLEEP_EXTRA_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] ACC_CYC = 4'(ACC_CYC_I > SEL_CYC_I ? ACC_CYC_I : SEL_CYC_I);
  localparam logic [3:0] SLEEP_CYC = 4'(SLEEP_CYC_I);

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    FPC_IDLE,
    FPC_UNL1,
    FPC_UNL2,
    FPC_PROG,
    FPC_ERS,
    FPC_CFGW
  } fpc_cmd_t;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fpc_bus_t;

  typedef struct packed {
    logic pgm;
    logic ers;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fpc_op_t;

  typedef struct packed {
    fpc_cmd_t cmd;
    logic secure;
    logic id_mode;
    logic cfg_sync;
    logic cust_lock;
    logic [CUST_WORDS-1:0] cust_used;
    logic busy;
    logic [15:0] eng_cnt;
    fpc_op_t op;
    logic pu_inh;
    logic started;
    logic we_prev;
    logic ce_prev;
    logic [ADDR_W-1:0] rd_addr;
    logic [3:0] acc_cnt;
    logic sleep;
    logic drive;
    logic [DATA_W-1:0] dq;
  } fpc_state_t;
endpackage

//--- test/fpc_arr_model.sv
// Array side model answering read data and software protection
`timescale 1ns/100ps
module fpc_arr_model (
  input wire logic [fpc_pkg::ADDR_W-1:0] arr_raddr, // Read address
  input wire logic [fpc_pkg::SECT_W-1:0] sw_prot_sector, // Queried sector
  input wire logic [fpc_pkg::SECT_W-1:0] prot_sect, // Sector held protected
  input wire logic prot_en, // Protection of prot_sect on
  output logic sw_prot, // Protection answer
  output logic [15:0] arr_rdata // Array word
);
  import fpc_pkg::*;
  // Stored words follow a fixed pattern of the address
  assign arr_rdata = arr_raddr[15:0] ^ 16'h5A5A;
  // Same-cycle answer, as the controller expects
  assign sw_prot = prot_en && (sw_prot_sector == prot_sect);
endmodule

//--- test/fpc_ctrl_chk.sv
// Port assertions of the flash protection controller
`timescale 1ns/100ps
module fpc_chk (
  input wire logic clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire fpc_pkg::fpc_bus_t bus, // Host bus
  input wire logic wp_n, // Write-protect
  input wire logic accel_lockout_input, // Acceleration input
  input wire logic supply_lockout_threshold, // Supply lockout
  input wire logic sw_prot, // Software protection answer
  input wire fpc_pkg::fpc_op_t arr_op, // Array operation
  input wire logic dq_oe, // Data output enable
  input wire logic auto_sleep, // Sleep state
  input wire logic busy, // Busy
  input wire logic secure_mode, // Secure mode
  input wire logic sync_mode, // Sync mode
  input wire logic factory_lock_flag, // Factory lock
  input wire logic customer_lock_flag // Customer lock
);
  import fpc_pkg::*;
  logic opq;
  // Any program or erase pulse to the array
  assign opq = arr_op.pgm || arr_op.ers;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_oe_off; bus.oe_n |-> !dq_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("outputs on with oe high");
  property p_lock_op; opq |-> $past(accel_lockout_input) && !$past(supply_lockout_threshold); endproperty
  a_lock_op: assert property (p_lock_op) else $error("operation under lockout");
  property p_prot_op;
    opq && !$past(secure_mode) |-> !$past(sw_prot) && ($past(wp_n) || !(arr_op.addr[23:15] inside {9'h000, 9'h1FF}));
  endproperty
  a_prot_op: assert property (p_prot_op) else $error("protected sector changed");
  property p_supply; supply_lockout_threshold |=> !busy && !secure_mode; endproperty
  a_supply: assert property (p_supply) else $error("active under supply lockout");
  property p_fact; factory_lock_flag; endproperty
  a_fact: assert property (p_fact) else $error("factory flag low");
  property p_cust; customer_lock_flag |=> customer_lock_flag; endproperty
  a_cust: assert property (p_cust) else $error("customer lock dropped");
  property p_sync_sleep; sync_mode && $past(sync_mode) |-> !auto_sleep; endproperty
  a_sync_sleep: assert property (p_sync_sleep) else $error("sleep in sync mode");
  property p_rst; !$past(nrst) |-> !secure_mode && !sync_mode && !busy; endproperty
  a_rst: assert property (p_rst) else $error("state kept over reset");
  property p_sleep; $rose(auto_sleep) |-> $stable(bus.addr) && bus.addr == $past(bus.addr, 4); endproperty
  a_sleep: assert property (p_sleep) else $error("early sleep");
endmodule
bind fpc_ctrl fpc_chk u_chk (.clk(clk), .nrst(nrst), .bus(bus), .wp_n(wp_n),
  .accel_lockout_input(accel_lockout_input), .supply_lockout_threshold(supply_lockout_threshold),
  .sw_prot(sw_prot), .arr_op(arr_op), .dq_oe(dq_oe), .auto_sleep(auto_sleep), .busy(busy),
  .secure_mode(secure_mode), .sync_mode(sync_mode), .factory_lock_flag(factory_lock_flag),
  .customer_lock_flag(customer_lock_flag));

//--- test/fpc_ctrl_tb.sv
// Self-checking bench of the flash protection controller
`timescale 1ns/100ps
module fpc_ctrl_tb;
  import fpc_pkg::*;
  typedef struct packed {logic k; logic [15:0] m; logic [15:0] e;} fpc_note_t;
  localparam logic [15:0] SER = 16'hC0DE; // Arbitrary serial pattern
  // Sector, then wp_n, accel, protection, supply, program expected
  localparam logic [14:0] CASES [7] = '{
    {10'h000, 5'b01000}, {10'h3FF, 5'b01000}, {10'h002, 5'b01001},
    {10'h000, 5'b11001}, {10'h001, 5'b11100},
    {10'h005, 5'b10000}, {10'h005, 5'b11010}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wp_n = 1'b1;
  logic acc = 1'b1;
  logic sup = 1'b0;
  logic pen = 1'b0;
  logic bn = 1'b0;
  logic [9:0] psect = 10'h000;
  logic [15:0] lf = 16'h3ECF;
  fpc_bus_t bus = '{1'b0, 1'b0, 1'b1, 24'h000555, 16'h00AA};
  logic swp, dq_oe, dv, sb, sl, by, sc, sy, cl, fl;
  logic [9:0] pq;
  logic [15:0] ard, dq;
  logic [23:0] ra;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  fpc_note_t q[$];
  // Controller with a short program time, array model beside it
  fpc_ctrl #(.PROG_CYCLES(32), .ERASE_CYCLES(4), .UNIQUE_SERIAL_ID(SER)) uut (.clk(clk), .nrst(nrst), .bus(bus),
    .wp_n(wp_n), .accel_lockout_input(acc), .supply_lockout_threshold(sup), .burst_next(bn), .sw_prot(swp),
    .arr_rdata(ard), .sw_prot_sector(pq), .arr_raddr(ra), .arr_op(), .dq_out(dq), .dq_oe(dq_oe),
    .data_valid(dv), .standby(sb), .auto_sleep(sl), .busy(by), .secure_mode(sc), .sync_mode(sy),
    .factory_lock_flag(fl), .customer_lock_flag(cl));
  fpc_arr_model u_arr (.arr_raddr(ra), .sw_prot_sector(pq), .prot_sect(psect), .prot_en(pen), .sw_prot(swp),
    .arr_rdata(ard));
  initial forever #10 clk = ~clk;
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end
  // Compare every pending note against the outputs
  always @(posedge clk) begin : mon
    fpc_note_t n;
    logic [15:0] g;
    while (q.size() > 0) begin
      n = q.pop_front();
      g = n.m & (n.k ? {7'h00, fl, dq_oe, dv, sb, sl, by, sc, sy, cl} : dq);
      samples_checked++;
      if (g !== n.e) begin
        errors++;
        $display("mismatch %s expected %h seen %h", n.k ? "status" : "dq_out", n.e, g);
      end
    end
  end
  function automatic logic [15:0] rnd(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic note(logic k, logic [15:0] m, logic [15:0] e);
    q.push_back('{k, m, e});
  endtask
  // One write cycle, taken on the strobe rise
  task automatic wr(logic [23:0] a, logic [15:0] d);
    @(negedge clk);
    bus = '{1'b0, 1'b0, 1'b1, a, d};
    @(negedge clk);
    bus.we_n = 1'b1;
    @(negedge clk);
    bus.ce_n = 1'b1;
  endtask
  task automatic cmd(logic [15:0] d);
    wr({12'h000, UNLOCK_A1}, CMD_UNL1_D);
    wr({12'h000, UNLOCK_A2}, CMD_UNL2_D);
    wr({12'h000, UNLOCK_A1}, d);
  endtask
  task automatic pg(logic [23:0] a, logic [15:0] d);
    cmd(CMD_PROG);
    wr(a, d);
  endtask
  task automatic idle;
    for (int i = 0; i < 100 && by !== 1'b0; i++) @(negedge clk);
  endtask
  // Read, then output enable off while still selected
  task automatic rd(logic [23:0] a, logic [15:0] e, logic s);
    @(negedge clk);
    bus = '{1'b0, 1'b1, 1'b0, a, 16'h0000};
    repeat (6) @(negedge clk);
    note(1'b0, 16'hFFFF, e);
    note(1'b1, 16'h00D0, {8'h00, 2'b11, 1'b0, s, 4'h0});
    @(negedge clk);
    bus.oe_n = 1'b1;
    @(negedge clk);
    note(1'b1, 16'h0080, 16'h0000);
    @(negedge clk);
    bus.ce_n = 1'b1;
  endtask
  // Program attempt under given pin levels; busy and standby show the outcome
  task automatic pcase(logic [9:0] s, logic [4:0] f);
    @(negedge clk);
    {wp_n, acc, pen, sup} = f[4:1];
    psect = s;
    lf = rnd(lf);
    pg({s, 14'h0123}, lf);
    @(negedge clk);
    note(1'b1, 16'h0028, f[0] ? 16'h0008 : 16'h0020);
    idle();
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    bus.we_n = 1'b1;
    @(negedge clk);
    bus.ce_n = 1'b1;
    wr({12'h000, UNLOCK_A2}, CMD_UNL2_D);
    wr({12'h000, UNLOCK_A1}, CMD_SEC_ENTER);
    @(negedge clk);
    note(1'b1, 16'h000F, 16'h0000);
    note(1'b1, 16'h0100, 16'h0100);
    rd(24'h012345, 16'h2345 ^ 16'h5A5A, 1'b1);
    $display("test power-up done");
    foreach (CASES[i]) pcase(CASES[i][14:5], CASES[i][4:0]);
    {wp_n, acc, pen, sup} = 4'b1100;
    // Sector erase of an unprotected sector runs the short erase engine
    cmd(CMD_ERASE);
    wr(24'h014000, CMD_ERASE_GO);
    @(negedge clk);
    note(1'b1, 16'h0028, 16'h0008);
    idle();
    $display("test protection done");
    cmd(CMD_SEC_ENTER);
    @(negedge clk);
    note(1'b1, 16'h0004, 16'h0004);
    rd(24'h000005, SER ^ 16'h0005, 1'b1);
    rd(24'h000080, ERASED_WORD, 1'b1);
    rd(24'h000100, INVALID_WORD, 1'b1);
    pg(24'h000081, 16'h1234);
    rd(24'h000081, INVALID_WORD, 1'b1);
    rd(24'h100010, 16'h0010 ^ 16'h5A5A, 1'b1);
    idle();
    rd(24'h000081, 16'h1234, 1'b1);
    cmd(CMD_CUST_LOCK);
    pg(24'h000082, 16'h0000);
    idle();
    note(1'b1, 16'h0001, 16'h0001);
    rd(24'h000082, ERASED_WORD, 1'b1);
    cmd(CMD_SEC_EXIT);
    rd(24'h000005, 16'h0005 ^ 16'h5A5A, 1'b1);
    cmd(CMD_SEC_EXIT);
    rd(24'h000003, 16'h00C0, 1'b1);
    wr(24'h000000, CMD_RESET);
    cmd(CMD_SEC_ENTER);
    @(negedge clk);
    sup = 1'b1;
    @(negedge clk);
    sup = 1'b0;
    note(1'b1, 16'h0004, 16'h0000);
    $display("test secure region done");
    cmd(CMD_CFG);
    wr(24'h000000, 16'h0001);
    rd(24'h000040, 16'h0040 ^ 16'h5A5A, 1'b0);
    cmd(CMD_SEC_ENTER);
    // Sync burst at the last secure word must wrap to the first
    @(negedge clk);
    bus = '{1'b0, 1'b1, 1'b0, 24'h0000FF, 16'h0000};
    repeat (6) @(negedge clk);
    bn = 1'b1;
    @(negedge clk);
    bn = 1'b0;
    note(1'b0, 16'hFFFF, ERASED_WORD);
    @(negedge clk);
    note(1'b0, 16'hFFFF, SER);
    @(negedge clk);
    bus.ce_n = 1'b1;
    pg(24'h008000, lf);
    @(negedge clk);
    note(1'b1, 16'h000E, 16'h000E);
    @(negedge clk);
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    note(1'b1, 16'h000E, 16'h0000);
    repeat (2) @(negedge clk);
    pg(24'h008000, lf);
    @(negedge clk);
    note(1'b1, 16'h0008, 16'h0008);
    idle();
    $display("test reset done");
    end_of_test();
  end
endmodule
